/* File: hw/optbyte_pkg.sv */
// Constants for the clock option byte and trim access block
package optbyte_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [13:0] IDX_OPTION = 14'h0001;
  localparam logic [13:0] IDX_TRIM_INDEX = 14'h0ff6;
  localparam logic [13:0] IDX_TRIM_VALUE = 14'h0ff7;
  localparam logic [13:0] IDX_CTRL = 14'h0100;
  localparam logic [13:0] IDX_STATUS = 14'h0101;

  // ************************************************************
  // Option byte fields
  // ************************************************************
  localparam int OPT_WAIT_HI = 7;
  localparam int OPT_WAIT_LO = 6;
  localparam int OPT_GUARD = 5;
  localparam int OPT_PRI_OFF = 4;
  localparam int OPT_SEC_KIND = 1;
  localparam int OPT_SEC_OFF = 0;

  // ************************************************************
  // Control and status fields
  // ************************************************************
  localparam int CTRL_SYS_XTAL = 0;
  localparam int CTRL_PER_SEC = 1;
  localparam int ST_DONE = 0;
  localparam int ST_PRI_ON = 1;
  localparam int ST_SEC_ON = 2;
  localparam int ST_BLOCK = 3;

  // ************************************************************
  // Trim window
  // ************************************************************
  localparam int TRIM_DEPTH = 32;
  localparam logic [7:0] TRIM_LAST = 8'h1f;
  localparam logic [7:0] INFO_BASE = 8'h20;
  localparam logic [7:0] TRIM_INDEX_RST = 8'h00;
  localparam logic [7:0] TRIM_VALUE_RST = 8'h00;

  // ************************************************************
  // Crystal wait counts, in oscillator ticks
  // ************************************************************
  localparam int WAIT_SEL0 = 500;
  localparam int WAIT_SEL1 = 1000;
  localparam int WAIT_SEL2 = 5000;
  localparam int WAIT_SEL3 = 10000;

  // ************************************************************
  // Bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : optbyte_pkg

/* File: hw/option_byte_trim_access.sv */
// Clock option byte loader, reset wait and trim register window
`timescale 1ns/100ps

module option_byte_trim_access #(
  parameter int WAIT0 = optbyte_pkg::WAIT_SEL0,
  parameter int WAIT1 = optbyte_pkg::WAIT_SEL1,
  parameter int WAIT2 = optbyte_pkg::WAIT_SEL2,
  parameter int WAIT3 = optbyte_pkg::WAIT_SEL3
) (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // Write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stored option byte and system inputs
  input wire logic [7:0] option_byte_stored,
  input wire logic ipo_tick,
  input wire logic lowvolt_detect,
  // Option byte programming request
  output logic option_prog_strobe,
  output logic [7:0] option_prog_data,
  // Clock and reset control outputs
  output logic cpu_release,
  output logic primary_osc_en,
  output logic secondary_osc_en,
  output logic secondary_osc_kind,
  output logic sysclk_from_crystal,
  output logic periph_clk_secondary,
  output logic flash_write_block,
  // Mapped information address of the trim window
  output logic [7:0] info_addr
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    S_LOAD = 3'b001,
    S_WAIT = 3'b010,
    S_RUN = 3'b100
  } seq_t;

  typedef struct packed {
    seq_t seq;                        // Reset sequence step
    logic [7:0] opt;                  // Latched option byte
    logic [1:0] ctrl;                 // Clock select control
    logic [7:0] tidx;                 // Trim index
    logic [31:0][7:0] tmem;           // Working trim bytes
    logic [13:0] wcnt;                // Crystal wait counter
    logic aw_rdy;
    logic ar_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic prog_stb;
    logic [7:0] prog_data;
    logic run;
    logic pri_en;
    logic sec_en;
    logic sec_kind;
    logic sys_xtal;
    logic per_sec;
    logic wr_block;
    logic [7:0] info;
  } state_t;

  state_t q;       // Registered state
  state_t next_q;  // Next state

  // ************************************************************
  // Helpers
  // ************************************************************
  // Wait length for a count select
  function automatic logic [13:0] wait_len(input logic [1:0] sel);
    logic [13:0] n;
    n = 14'(WAIT0);
    unique case (sel)
      2'b00: n = 14'(WAIT0);
      2'b01: n = 14'(WAIT1);
      2'b10: n = 14'(WAIT2);
      2'b11: n = 14'(WAIT3);
    endcase
    return n;
  endfunction : wait_len

  // Status word from current state
  function automatic logic [31:0] status_word(input state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[optbyte_pkg::ST_DONE] = s.run;
    w[optbyte_pkg::ST_PRI_ON] = s.pri_en;
    w[optbyte_pkg::ST_SEC_ON] = s.sec_en;
    w[optbyte_pkg::ST_BLOCK] = s.wr_block;
    return w;
  endfunction : status_word

  logic [13:0] widx;      // Write word index
  logic [13:0] ridx;      // Read word index
  logic tidx_ok;          // Trim index inside window
  logic guard_hit;        // Flash writes blocked now

  assign widx = s_axi_awaddr[15:2];
  assign ridx = s_axi_araddr[15:2];
  assign tidx_ok = (q.tidx <= optbyte_pkg::TRIM_LAST);
  assign guard_hit = q.opt[optbyte_pkg::OPT_GUARD] & lowvolt_detect;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_q = q;
    next_q.prog_stb = 1'b0;

    // Reset sequence
    unique case (q.seq)
      S_LOAD: begin
        next_q.opt = option_byte_stored;
        next_q.wcnt = 14'h0000;
        if (option_byte_stored[optbyte_pkg::OPT_PRI_OFF]) begin
          next_q.seq = S_RUN;
          next_q.run = 1'b1;
        end else begin
          next_q.seq = S_WAIT;
        end
      end
      S_WAIT: begin
        if (ipo_tick) begin
          if (q.wcnt == wait_len(q.opt[7:6]) - 14'h0001) begin
            next_q.seq = S_RUN;
            next_q.run = 1'b1;
          end else begin
            next_q.wcnt = q.wcnt + 14'h0001;
          end
        end
      end
      S_RUN: begin
        // Processor running
        next_q.run = 1'b1;
      end
    endcase

    next_q.pri_en = ~next_q.opt[optbyte_pkg::OPT_PRI_OFF];
    next_q.sec_en = ~next_q.opt[optbyte_pkg::OPT_SEC_OFF];
    next_q.sec_kind = next_q.opt[optbyte_pkg::OPT_SEC_KIND];
    next_q.wr_block = next_q.opt[optbyte_pkg::OPT_GUARD] & lowvolt_detect;
    next_q.info = q.tidx + optbyte_pkg::INFO_BASE;

    // Write address and data taken together
    if (q.aw_rdy) begin
      next_q.aw_rdy = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = optbyte_pkg::RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        unique case (widx)
          optbyte_pkg::IDX_OPTION: begin
            if (guard_hit) begin
              next_q.bresp = optbyte_pkg::RESP_SLVERR;
            end else begin
              next_q.prog_stb = 1'b1;
              next_q.prog_data = s_axi_wdata[7:0];
            end
          end
          optbyte_pkg::IDX_TRIM_INDEX: begin
            next_q.tidx = s_axi_wdata[7:0];
            next_q.info = s_axi_wdata[7:0] + optbyte_pkg::INFO_BASE;
          end
          optbyte_pkg::IDX_TRIM_VALUE: begin
            if (tidx_ok) begin
              next_q.tmem[q.tidx[4:0]] = s_axi_wdata[7:0];
            end
          end
          optbyte_pkg::IDX_CTRL: begin
            next_q.ctrl = s_axi_wdata[1:0];
          end
          optbyte_pkg::IDX_STATUS: begin
            // Status is read only
          end
          default: begin
            next_q.bresp = optbyte_pkg::RESP_SLVERR;
          end
        endcase
      end
    end else if (s_axi_awvalid && s_axi_wvalid && !q.bvalid) begin
      next_q.aw_rdy = 1'b1;
    end

    // Write response retires
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // Read address taken
    if (q.ar_rdy) begin
      next_q.ar_rdy = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = optbyte_pkg::RESP_OKAY;
      next_q.rdata = 32'h0000_0000;
      unique case (ridx)
        optbyte_pkg::IDX_OPTION: begin
          next_q.rdata[7:0] = q.opt;
        end
        optbyte_pkg::IDX_TRIM_INDEX: begin
          next_q.rdata[7:0] = q.tidx;
        end
        optbyte_pkg::IDX_TRIM_VALUE: begin
          if (tidx_ok) begin
            next_q.rdata[7:0] = q.tmem[q.tidx[4:0]];
          end
        end
        optbyte_pkg::IDX_CTRL: begin
          next_q.rdata[1:0] = q.ctrl;
        end
        optbyte_pkg::IDX_STATUS: begin
          next_q.rdata = status_word(q);
        end
        default: begin
          next_q.rresp = optbyte_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_arvalid && !q.rvalid) begin
      next_q.ar_rdy = 1'b1;
    end

    // Read data retires
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // crystal as system clock only by control
    next_q.sys_xtal = next_q.run & next_q.ctrl[optbyte_pkg::CTRL_SYS_XTAL];
    next_q.per_sec = next_q.run & next_q.ctrl[optbyte_pkg::CTRL_PER_SEC];
    // Selected crystals stay running
    if (next_q.sys_xtal) begin
      next_q.pri_en = 1'b1;
    end
    if (next_q.per_sec) begin
      next_q.sec_en = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.seq <= S_LOAD;
      q.tidx <= optbyte_pkg::TRIM_INDEX_RST;
      q.info <= optbyte_pkg::INFO_BASE;
      // Oscillators run until the byte is read
      q.pri_en <= 1'b1;
      q.sec_en <= 1'b1;
    end else if (aclken) begin
      q <= next_q;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.aw_rdy;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign option_prog_strobe = q.prog_stb;
  assign option_prog_data = q.prog_data;
  assign cpu_release = q.run;
  assign primary_osc_en = q.pri_en;
  assign secondary_osc_en = q.sec_en;
  assign secondary_osc_kind = q.sec_kind;
  assign sysclk_from_crystal = q.sys_xtal;
  assign periph_clk_secondary = q.per_sec;
  assign flash_write_block = q.wr_block;
  assign info_addr = q.info;

endmodule : option_byte_trim_access

/* File: verif/option_byte_trim_access_props.sv */
// Concurrent checks on the option byte and trim block ports
`timescale 1ns/100ps

module option_byte_trim_access_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock control
  input wire logic lowvolt_detect,
  input wire logic cpu_release,
  input wire logic primary_osc_en,
  input wire logic secondary_osc_en,
  input wire logic sysclk_from_crystal,
  input wire logic periph_clk_secondary,
  input wire logic flash_write_block
);
  // ************************************************************
  // Checks, all on the bus clock
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wr_answer;
    s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_axi_arready && s_axi_arvalid |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_guard;
    flash_write_block |-> $past(lowvolt_detect);
  endproperty
  a_guard: assert property (p_guard) else $error("write block without low voltage");
  property p_sysclk;
    sysclk_from_crystal |-> cpu_release && primary_osc_en;
  endproperty
  a_sysclk: assert property (p_sysclk) else $error("crystal clock select early");
  property p_periph;
    periph_clk_secondary |-> cpu_release && secondary_osc_en;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral clock select early");
  property p_release;
    cpu_release |=> cpu_release;
  endproperty
  a_release: assert property (p_release) else $error("processor release dropped");
endmodule : option_byte_trim_access_props

bind option_byte_trim_access option_byte_trim_access_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .lowvolt_detect, .cpu_release, .primary_osc_en,
  .secondary_osc_en, .sysclk_from_crystal, .periph_clk_secondary, .flash_write_block
);

/* File: verif/option_byte_trim_access_test.sv */
// Self-checking bench for the option byte and trim block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end

module option_byte_trim_access_test;
  // Short crystal wait counts: select k waits W_BASE + k ticks
  localparam int W_BASE = 3;
  // Byte addresses of the registers
  localparam logic [15:0] A_OPT = {optbyte_pkg::IDX_OPTION, 2'b00};
  localparam logic [15:0] A_TIX = {optbyte_pkg::IDX_TRIM_INDEX, 2'b00};
  localparam logic [15:0] A_TVAL = {optbyte_pkg::IDX_TRIM_VALUE, 2'b00};
  localparam logic [15:0] A_CTRL = {optbyte_pkg::IDX_CTRL, 2'b00};
  localparam logic [15:0] A_ST = {optbyte_pkg::IDX_STATUS, 2'b00};
  // Design inputs
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aclken = 1'b1;
  logic [15:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] option_byte_stored = '0;
  logic ipo_tick = 1'b0;
  logic lowvolt_detect = 1'b0;
  // Design outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic option_prog_strobe, cpu_release, primary_osc_en, secondary_osc_en;
  logic secondary_osc_kind, sysclk_from_crystal, periph_clk_secondary, flash_write_block;
  logic [7:0] option_prog_data, info_addr;
  // Tallies
  int fails = 0;
  int samples_checked = 0;
  // Cycles before the response ready goes up
  int lag = 0;
  // Option programming strobes seen so far
  int prog_seen = 0;

  option_byte_trim_access #(
    .WAIT0(W_BASE), .WAIT1(W_BASE + 1), .WAIT2(W_BASE + 2), .WAIT3(W_BASE + 3)
  ) DUT (
    .aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .option_byte_stored,
    .ipo_tick, .lowvolt_detect, .option_prog_strobe, .option_prog_data, .cpu_release,
    .primary_osc_en, .secondary_osc_en, .secondary_osc_kind, .sysclk_from_crystal,
    .periph_clk_secondary, .flash_write_block, .info_addr
  );

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // Count programming strobes one edge after they are launched
  always @(posedge aclk) begin
    if (option_prog_strobe === 1'b1) prog_seen++;
  end

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Bus write: address and data together, response ready raised after lag cycles
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      // Late ready makes the slave hold its answer
      if (n >= lag) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Bus read
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      // Late ready makes the slave hold its answer
      if (n >= lag) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Let registered outputs land
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  // Reset for five cycles with a given stored byte
  task automatic rst(input logic [7:0] o);
    @(posedge aclk);
    option_byte_stored <= o;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
  endtask : rst

  // Wait counts for every select value
  task automatic t_wait;
    logic [1:0] s;
    @(posedge aclk);
    lowvolt_detect <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      s = k[1:0];
      rst({s, 4'b0000, s[0], s[1]});
      `CHK({primary_osc_en, secondary_osc_en}, {1'b1, !s[1]})
      `CHK(secondary_osc_kind, s[0])
      `CHK(flash_write_block, 1'b0)
      // Clock enable low freezes the wait count
      @(posedge aclk);
      aclken <= 1'b0;
      ipo_tick <= 1'b1;
      repeat (8) @(posedge aclk);
      aclken <= 1'b1;
      ipo_tick <= 1'b0;
      #1;
      `CHK(cpu_release, 1'b0)
      for (int i = 0; i < W_BASE + k; i++) begin
        @(posedge aclk);
        ipo_tick <= 1'b1;
        @(posedge aclk);
        ipo_tick <= 1'b0;
        #1;
        `CHK(cpu_release, i == W_BASE + k - 1)
      end
    end
    $display("wait counts done");
  endtask : t_wait

  // Low-voltage guard, short reset, option read and write
  task automatic t_guard;
    logic [1:0] r;
    logic [31:0] d;
    rst(8'h32);
    `CHK({cpu_release, primary_osc_en}, 2'b10)
    settle();
    `CHK(flash_write_block, 1'b1)
    wr(A_OPT, 32'h0000_00c1, r);
    `CHK(r, optbyte_pkg::RESP_SLVERR)
    @(posedge aclk);
    lowvolt_detect <= 1'b0;
    settle();
    `CHK(flash_write_block, 1'b0)
    `CHK(prog_seen, 0)
    wr(A_OPT, 32'h0000_00c1, r);
    settle();
    `CHK({r, option_prog_data}, {optbyte_pkg::RESP_OKAY, 8'hc1})
    `CHK(prog_seen, 1)
    rd(A_OPT, d, r);
    `CHK(d, 32'h0000_0032)
    $display("guard done");
  endtask : t_guard

  // Trim window at both ends and beyond
  task automatic t_trim;
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] ix[3] = '{8'h00, 8'h1f, 8'h20};
    for (int i = 0; i < 3; i++) begin
      wr(A_TIX, {24'h0, ix[i]}, r);
      settle();
      `CHK(info_addr, ix[i] + optbyte_pkg::INFO_BASE)
      wr(A_TVAL, {24'h0, ix[i] ^ 8'ha5}, r);
      rd(A_TIX, d, r);
      `CHK(d, {24'h0, ix[i]})
      rd(A_TVAL, d, r);
      `CHK(d, (ix[i] > optbyte_pkg::TRIM_LAST) ? 32'h0 : {24'h0, ix[i] ^ 8'ha5})
    end
    wr(A_TIX, 32'h0, r);
    rd(A_TVAL, d, r);
    `CHK(d, 32'h0000_00a5)
    $display("trim done");
  endtask : t_trim

  // Clock selects after release, status and an unmapped place
  task automatic t_ctrl;
    logic [1:0] r;
    logic [31:0] d;
    rst(8'h11);
    // Answers must stand while ready is held back
    lag = 3;
    `CHK({primary_osc_en, secondary_osc_en}, 2'b00)
    wr(A_CTRL, 32'h0000_0001, r);
    settle();
    `CHK({sysclk_from_crystal, primary_osc_en}, 2'b11)
    wr(A_CTRL, 32'h0000_0002, r);
    settle();
    `CHK({periph_clk_secondary, secondary_osc_en, sysclk_from_crystal}, 3'b110)
    rd(A_ST, d, r);
    `CHK(d[2:0], 3'b101)
    rd(16'h0808, d, r);
    `CHK({r, d}, {optbyte_pkg::RESP_SLVERR, 32'h0})
    $display("control done");
  endtask : t_ctrl

  // Main sequence
  initial begin
    t_wait();
    t_guard();
    t_trim();
    t_ctrl();
    finish_test();
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : option_byte_trim_access_test
